// ===== include/ialu_map.svh
`ifndef IALU_MAP_SVH
`define IALU_MAP_SVH
`define IALU_PC_IDX 4'hF
`define IALU_ALIGN_MASK 32'hFFFFFFFC
`define IALU_BIT0_MASK 32'hFFFFFFFE
`define IALU_ZERO32 32'h00000000
`define IALU_HI_MSB 31
`define IALU_HI_LSB 16
`define IALU_LO_MSB 15
`define IALU_LO_LSB 0
`define IALU_MSB 31
`define IALU_CARRY_BIT 32
`endif

// ===== include/ialu_pkg.sv
package ialu_pkg;
   // operation selects, one-hot
   typedef enum logic [10:0] {
      OP_ADD = 11'h001,
      OP_SUB = 11'h002,
      OP_ADC = 11'h004,
      OP_SUBC = 11'h008,
      OP_AND = 11'h010,
      OP_OR = 11'h020,
      OP_XOR = 11'h040,
      OP_ANDN = 11'h080,
      OP_ORNOT = 11'h100,
      OP_HASX = 11'h200,
      OP_HSAX = 11'h400
   } ialu_op_t;

   typedef struct packed {
      logic valid;         // instruction presented
      logic condPass;      // condition check passed
      ialu_op_t op;        // operation
      logic setFlags;      // flag-setting variant
      logic [3:0] rn;      // first operand register index
      logic [3:0] rd;      // destination register index
      logic rdPresent;     // destination given
      logic rmIsReg;       // second operand from a register
      logic [31:0] opA;    // first operand value
      logic [31:0] opB;    // second operand value
   } ialu_req_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } ialu_flags_t;

   typedef struct packed {
      logic we;            // register write strobe
      logic [3:0] rd;      // register index written
      logic [31:0] data;   // value written
      logic branch;        // pc written, branch taken
   } ialu_wb_t;
endpackage : ialu_pkg

// ===== rtl/ialu_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "ialu_map.svh"
module ialu_datapath (
   input wire logic clk,                 // core clock
   input wire logic rst_n,               // async reset, active low
   input wire logic clkEn,               // freezes all state when low
   input wire ialu_pkg::ialu_req_t req,  // decoded instruction and operands
   output var ialu_pkg::ialu_wb_t wb,    // register write back
   output var ialu_pkg::ialu_flags_t flags // condition flags
);
   // first operand path
   logic pcBase; // first operand names the program counter
   logic pcAddBranch; // pc plus register into pc
   logic [31:0] a; // first operand after alignment

   // adder path
   logic [31:0] bIn; // second operand, inverted for subtracts
   logic cIn; // adder carry in
   logic [32:0] sum; // adder result with carry out

   // operation classes
   logic isArith;
   logic isLogic;
   logic isHalf;
   logic isSub;
   logic useCarry;

   // logic unit
   logic [31:0] logicRes;

   // halfword exchange unit
   logic [15:0] aTop;
   logic [15:0] bBot;
   logic [15:0] hSum;
   logic [15:0] hDif;
   logic [31:0] halfRes;

   // result, destination and enables
   logic [31:0] res;
   logic [3:0] dest;
   logic doWrite;
   logic doFlags;
   ialu_pkg::ialu_flags_t nxtFlags;

   // registers behind the outputs
   logic we_q;
   logic [3:0] rd_q;
   logic [31:0] data_q;
   logic branch_q;
   ialu_pkg::ialu_flags_t flags_q;

   // pc base operand alignment
   always_comb begin
      pcBase = (req.rn == `IALU_PC_IDX);
      if (pcBase) begin
         a = req.opA & `IALU_ALIGN_MASK;
      end else begin
         a = req.opA;
      end
   end

   // pc plus register into pc, a branch
   always_comb begin
      pcAddBranch = pcBase && req.rdPresent && (req.rd == `IALU_PC_IDX)
         && req.rmIsReg && (req.op == ialu_pkg::OP_ADD);
   end

   // operation class decode from one-hot select
   always_comb begin
      isArith = 1'h0;
      isLogic = 1'h0;
      isHalf = 1'h0;
      isSub = 1'h0;
      useCarry = 1'h0;
      unique case (req.op)
         ialu_pkg::OP_ADD: begin
            isArith = 1'h1;
         end
         ialu_pkg::OP_SUB: begin
            isArith = 1'h1;
            isSub = 1'h1;
         end
         ialu_pkg::OP_ADC: begin
            isArith = 1'h1;
            useCarry = 1'h1;
         end
         ialu_pkg::OP_SUBC: begin
            isArith = 1'h1;
            isSub = 1'h1;
            useCarry = 1'h1;
         end
         ialu_pkg::OP_AND, ialu_pkg::OP_OR, ialu_pkg::OP_XOR,
         ialu_pkg::OP_ANDN, ialu_pkg::OP_ORNOT: begin
            isLogic = 1'h1;
         end
         ialu_pkg::OP_HASX, ialu_pkg::OP_HSAX: begin
            isHalf = 1'h1;
         end
         default: begin
            isArith = 1'h0; // illegal select leaves carry alone
         end
      endcase
   end

   // adder operand and carry in; subtract carry is not borrow
   always_comb begin
      bIn = isSub ? ~req.opB : req.opB;
      if (useCarry) begin
         cIn = flags_q.c;
      end else begin
         cIn = isSub;
      end
      sum = {1'h0, a} + {1'h0, bIn} + {32'h00000000, cIn};
   end

   // bitwise logic unit
   always_comb begin
      logicRes = a & req.opB;
      unique case (req.op)
         ialu_pkg::OP_AND: logicRes = a & req.opB;
         ialu_pkg::OP_OR: logicRes = a | req.opB;
         ialu_pkg::OP_XOR: logicRes = a ^ req.opB;
         ialu_pkg::OP_ANDN: logicRes = a & ~req.opB;
         ialu_pkg::OP_ORNOT: logicRes = a | ~req.opB;
         default: logicRes = a & req.opB;
      endcase
   end

   // halfword exchange add and subtract, wraps on overflow
   always_comb begin
      aTop = a[`IALU_HI_MSB:`IALU_HI_LSB];
      bBot = req.opB[`IALU_LO_MSB:`IALU_LO_LSB];
      hSum = aTop + bBot;
      hDif = aTop - bBot;
      halfRes = {hSum, hDif};
   end

   // result selection
   always_comb begin
      if (isLogic) begin
         res = logicRes;
      end else if (isHalf) begin
         res = halfRes;
      end else if (pcAddBranch) begin
         res = sum[`IALU_MSB:`IALU_LO_LSB] & `IALU_BIT0_MASK;
      end else begin
         res = sum[`IALU_MSB:`IALU_LO_LSB];
      end
   end

   // destination, write and flag enables
   always_comb begin
      dest = req.rdPresent ? req.rd : req.rn;
      doWrite = req.valid && req.condPass;
      doFlags = doWrite && req.setFlags && !isHalf && !pcBase;
   end

   // next flags; logic ops keep carry and overflow
   always_comb begin
      nxtFlags.n = res[`IALU_MSB];
      nxtFlags.z = (res == `IALU_ZERO32);
      nxtFlags.c = isArith ? sum[`IALU_CARRY_BIT] : flags_q.c;
      nxtFlags.v = isArith ? ((a[`IALU_MSB] == bIn[`IALU_MSB])
         && (sum[`IALU_MSB] != a[`IALU_MSB])) : flags_q.v;
   end

   // write strobe, one cycle after operands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         we_q <= 1'h0;
      end else if (clkEn) begin
         we_q <= doWrite;
      end
   end

   // destination index
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= '0;
      end else if (clkEn) begin
         rd_q <= dest;
      end
   end

   // written value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= `IALU_ZERO32;
      end else if (clkEn) begin
         data_q <= res;
      end
   end

   // branch marker, pc written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         branch_q <= 1'h0;
      end else if (clkEn) begin
         branch_q <= doWrite && (dest == `IALU_PC_IDX);
      end
   end

   // condition flags register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else if (clkEn && doFlags) begin
         flags_q <= nxtFlags;
      end
   end

   // outputs straight from the registers
   assign wb = '{
      we: we_q,
      rd: rd_q,
      data: data_q,
      branch: branch_q
   };
   assign flags = flags_q;
endmodule : ialu_datapath
`default_nettype wire

// ===== tb/ialu_datapath_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ialu_datapath_chk (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic clkEn, // enable
   input wire ialu_pkg::ialu_req_t req, // request
   input wire ialu_pkg::ialu_wb_t wb, // write back
   input wire ialu_pkg::ialu_flags_t flags // flags
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic go = clkEn && req.valid && req.condPass; // taken
   // outputs tied to their causes
   property p_lat; go |=> wb.we; endproperty
   a_lat: assert property (p_lat) else $error("no write");
   property p_dst; go && !req.rdPresent |=> wb.rd == $past(req.rn); endproperty
   a_dst: assert property (p_dst) else $error("bad dest");
   property p_hold; clkEn && !req.setFlags |=> $stable(flags); endproperty
   a_hold: assert property (p_hold) else $error("flags moved");
   property p_hx; clkEn && |req.op[10:9] |=> $stable(flags); endproperty
   a_hx: assert property (p_hx) else $error("flags moved");
   property p_br; wb.branch |-> wb.we && !wb.data[0]; endproperty
   a_br: assert property (p_br) else $error("odd branch");
   property p_and; go && req.op[4] |=> wb.data == ($past(req.opA) & $past(req.opB)); endproperty
   a_and: assert property (p_and) else $error("bad and");
   property p_adc; go && req.op[2] && !(&req.rn)
      |=> wb.data == $past(req.opA) + $past(req.opB) + $past(flags.c); endproperty
   a_adc: assert property (p_adc) else $error("bad carry add");
   property p_pc; go && req.op[0] && &req.rn && !req.rmIsReg
      |=> wb.data == ($past(req.opA) & 32'hFFFFFFFC) + $past(req.opB); endproperty
   a_pc: assert property (p_pc) else $error("pc not aligned");
   property p_frz; !clkEn |=> $stable(wb) && $stable(flags); endproperty
   a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule : ialu_datapath_chk
bind ialu_datapath ialu_datapath_chk ialu_datapath_chk_i (.clk, .rst_n, .clkEn, .req, .wb, .flags);
`default_nettype wire

// ===== tb/ialu_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module ialu_regfile (
   input wire logic clk, // core clock
   input wire ialu_pkg::ialu_wb_t wb // result from datapath
);
   logic [31:0] regs_q [16]; // register file
   // store each write back
   always_ff @(posedge clk) if (wb.we) regs_q[wb.rd] <= wb.data;
endmodule : ialu_regfile
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   ialu_pkg::ialu_req_t req = '0;
   ialu_pkg::ialu_wb_t wb;
   ialu_pkg::ialu_flags_t flags;
   logic [3:0] fm = 4'h0; // model flags
   logic clkEn = 1'h1; // clock enable
   logic enSeen = 1'h1; // enable seen at last edge
   logic [40:0] q[$]; // expected results
   int mismatches = 0;
   int check_count = 0;
   always #5 clk = ~clk;
   ialu_datapath ialu_datapath_i (.clk, .rst_n, .clkEn, .req, .wb, .flags);
   always @(posedge clk) enSeen <= clkEn;
   ialu_regfile ialu_regfile_i (.clk, .wb);
   task chk(input logic [40:0] got, exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t in result", $time);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d errors %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // drive one instruction, note its result
   task issue(logic [10:0] o, logic f, p, logic [3:0] n, d, logic r, logic [31:0] a, b);
      logic [31:0] x, y, s;
      logic [32:0] t;
      logic [3:0] e, g;
      x = n == 4'hF ? a & 32'hFFFFFFFC : a;
      y = o[1] | o[3] ? ~b : b;
      t = x + y + 33'(o[2] | o[3] ? fm[1] : o[1]);
      s = o[4] ? x & b : o[5] ? x | b : o[6] ? x ^ b : o[7] ? x & ~b : o[8] ? x | ~b :
         |o[10:9] ? {x[31:16] + b[15:0], x[31:16] - b[15:0]} : t[31:0];
      e = r ? d : n;
      if (o[0] && n == 4'hF && e == 4'hF) s[0] = 1'h0;
      g = fm;
      if (f && n != 4'hF && !o[9] && !o[10]) g[3:2] = {s[31], ~|s};
      if (f && n != 4'hF && |o[3:0]) g[1:0] = {t[32], x[31] == y[31] && s[31] != x[31]};
      @(posedge clk);
      req <= '{1'h1, p, ialu_pkg::ialu_op_t'(o), f, n, d, r, !(n == 4'hF && e != 4'hF), a, b};
      if (p) fm = g;
      if (p) q.push_back({e, s, e == 4'hF, g});
   endtask : issue
   // compare each write back with the oldest note
   always @(negedge clk) if (wb.we === 1'h1 && enSeen) chk({wb.rd, wb.data, wb.branch, flags}, q.pop_front());
   // main sequence
   initial begin
      void'($urandom(55));
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      issue(11'h001, 1'h1, 1'h1, 4'hF, 4'h2, 1'h1, 32'h1003, 32'h00000FFF);
      issue(11'h001, 1'h0, 1'h1, 4'hF, 4'hF, 1'h1, 32'h2000, 32'h5);
      for (int i = 0; i < 550; i++)
         issue(11'h001 << i % 11, 1'($urandom), 1'($urandom % 4 > 0), 4'($urandom % 13),
            4'($urandom % 13), 1'($urandom), $urandom, $urandom);
      @(posedge clk);
      clkEn <= 1'h0; // freeze with the last request still shown
      repeat (3) @(posedge clk);
      req.valid <= 1'h0;
      clkEn <= 1'h1;
      repeat (3) @(posedge clk);
      if (q.size() != 0) mismatches++;
      end_sim();
   end
   // hang guard
   initial begin
      #20000;
      mismatches++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
